// file: common/alsc_consts.svh
`ifndef ALSC_CONSTS_SVH
`define ALSC_CONSTS_SVH

// Register indices; byte address is four times the index
`define ALSC_IDX_IR_SEL 6'h0E
`define ALSC_IDX_AUX_SEL 6'h0F
`define ALSC_IDX_VIS_REC 6'h10
`define ALSC_IDX_VIS_GAIN 6'h11
`define ALSC_IDX_VIS_MISC 6'h12
`define ALSC_IDX_HYST 6'h16
`define ALSC_IDX_CTRL 6'h20
`define ALSC_IDX_STATUS 6'h21
`define ALSC_IDX_IRQ_STAT 6'h22
`define ALSC_IDX_IRQ_MASK 6'h23
`define ALSC_IDX_LOW_TH 6'h24
`define ALSC_IDX_HIGH_TH 6'h25
`define ALSC_IDX_HISTORY 6'h26
`define ALSC_IDX_RES_VIS 6'h27
`define ALSC_IDX_RES_IR 6'h28
`define ALSC_IDX_RES_AUX 6'h29
`define ALSC_IDX_HYST_EXP 6'h2A

// Reset values
`define ALSC_RST_IR_SEL 8'h00
`define ALSC_RST_AUX_SEL 8'h65
`define ALSC_RST_VIS_REC 8'h70
`define ALSC_RST_VIS_GAIN 8'h00
`define ALSC_RST_VIS_MISC 8'h00
`define ALSC_RST_HYST 8'h48
`define ALSC_RST_HISTORY 8'h03
`define ALSC_RST_LOW_TH 16'h0000
`define ALSC_RST_HIGH_TH 16'hFFFF

// Writable bits; reserved bits read as zero
`define ALSC_WMASK_VIS_REC 8'h70
`define ALSC_WMASK_VIS_GAIN 8'h07
`define ALSC_WMASK_VIS_MISC 8'h20
`define ALSC_REC_MSB 6
`define ALSC_REC_LSB 4
`define ALSC_GAIN_MSB 2
`define ALSC_RANGE_BIT 5

// Input select codes
`define ALSC_MUX_IR_SMALL 8'h00
`define ALSC_MUX_IR_LARGE 8'h03
`define ALSC_MUX_AUX_TEMP 8'h65
`define ALSC_MUX_AUX_VDD 8'h75

// Control and interrupt bits
`define ALSC_CTRL_VIS 0
`define ALSC_CTRL_IR 1
`define ALSC_CTRL_AUX 2
`define ALSC_IRQ_DONE 0
`define ALSC_IRQ_HIGH 1
`define ALSC_IRQ_LOW 2

// Timing
`define ALSC_CLK_NS 50
`define ALSC_ADC_CLK_NS 50
`define ALSC_ADC_CLK_CYC ((`ALSC_ADC_CLK_NS + `ALSC_CLK_NS - 1) / `ALSC_CLK_NS)
`define ALSC_INTEG_ADC_CLKS 10'h010
`define ALSC_IR_DEF_REC 3'h7
`define ALSC_IR_DEF_GAIN 3'h0

`endif

// file: common/alsc_pkg.sv
package alsc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECOV = 5'h02,
    ST_INTEG = 5'h04,
    ST_SAMPLE = 5'h08,
    ST_EVAL = 5'h10
  } alsc_state_e;

  typedef enum logic [1:0] {
    CH_VIS = 2'h0,
    CH_IR = 2'h1,
    CH_AUX = 2'h2
  } alsc_chan_e;

  typedef enum logic [2:0] {
    PD_NONE = 3'h0,
    PD_VIS = 3'h1,
    PD_IR_SMALL = 3'h2,
    PD_IR_LARGE = 3'h3,
    PD_TEMP = 3'h4,
    PD_VDD = 3'h5
  } alsc_pd_e;

  // Steering of the analog front end
  typedef struct packed {
    alsc_pd_e pdSel;
    logic refGround;
    logic rangeHigh;
    logic integrate;
    logic [2:0] gain;
    logic adcTick;
  } alsc_fe_s;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } alsc_sample_s;

endpackage : alsc_pkg

// file: hw/alsc_adc_timer.sv
`timescale 1ns/1ps
`include "alsc_consts.svh"

module alsc_adc_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Control
  input wire logic load,
  input wire logic [2:0] gain,
  input wire logic [9:0] adcClocks,
  // Status
  output logic adcTick,
  output logic done
);

  logic [7:0] presc;
  logic [9:0] remain;
  logic running;
  logic [7:0] termCount;

  // One ADC clock spans the base period times two to the gain
  assign termCount = 8'((`ALSC_ADC_CLK_CYC << gain) - 1);
  assign adcTick = running && (presc == termCount);
  assign done = adcTick && (remain == 10'h001);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      presc <= 8'h00;
      remain <= 10'h000;
      running <= 1'b0;
    end else if (load) begin
      presc <= 8'h00;
      remain <= adcClocks;
      running <= 1'b1;
    end else if (adcTick) begin
      presc <= 8'h00;
      remain <= remain - 10'h001;
      running <= !done;
    end else if (running) begin
      presc <= presc + 8'h01;
    end
  end

endmodule : alsc_adc_timer

// file: hw/alsc_light_setup.sv
`timescale 1ns/1ps
`include "alsc_consts.svh"

// Notes on behaviour
// - IR select: 0x00 small, 0x03 large
// - Aux select: 0x65 temperature, 0x75 supply
// - Aux measurements always referenced to ground
// - Reset: aux select 0x65, hysteresis 0x48
// - Recovery code picks 1..511 ADC clocks
// - Recovery ADC clock is 50 ns times 2^gain
// - Gain scales visible integration by 2^gain
// - Maximum scaling 128 at code 0x7
// - Gain divides ADC clock by 2^gain
// - Range bit 5 selects high range
// - Legacy silicon: visible settings govern IR
// - Hysteresis widens both lower and upper thresholds
// - Hysteresis compressed 8 bits, 0x48 is 24
// - Status changes after masked consecutive samples
module alsc_light_setup (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Silicon revision strap, high on legacy parts
  input wire logic legacyRev,
  // Analog front end
  output alsc_pkg::alsc_fe_s feCtrl,
  output logic sampleReq,
  input alsc_pkg::alsc_sample_s sample,
  // Interrupt
  output logic irq
);

  // Setting registers
  logic [7:0] irInputSelect;
  logic [7:0] auxiliaryInputSelect;
  logic [7:0] visibleRecoveryConfig;
  logic [7:0] visibleIntegrationScale;
  logic [7:0] visibleMiscConfig;
  logic [7:0] lightThresholdHysteresis;
  logic [7:0] lightConsecutiveCount;
  logic [15:0] lightLowerThreshold;
  logic [15:0] lightUpperThreshold;
  logic [2:0] irqStat;
  logic [2:0] irqMask;
  logic [15:0] resVis;
  logic [15:0] resIr;
  logic [15:0] resAux;

  // Measurement state
  alsc_pkg::alsc_state_e state;
  alsc_pkg::alsc_state_e next_state;
  alsc_pkg::alsc_chan_e chan;
  alsc_pkg::alsc_fe_s next_feCtrl;
  logic aboveUpper;
  logic belowLower;
  logic legacySync1;
  logic legacySync2;

  function automatic alsc_pkg::alsc_pd_e alscDecodeMux(
    input alsc_pkg::alsc_chan_e ch,
    input logic [7:0] code
  );
    alsc_pkg::alsc_pd_e pd;
    pd = alsc_pkg::PD_NONE;
    case (ch)
      alsc_pkg::CH_VIS: pd = alsc_pkg::PD_VIS;
      alsc_pkg::CH_IR: begin
        if (code == `ALSC_MUX_IR_SMALL) pd = alsc_pkg::PD_IR_SMALL;
        else if (code == `ALSC_MUX_IR_LARGE) pd = alsc_pkg::PD_IR_LARGE;
      end
      alsc_pkg::CH_AUX: begin
        if (code == `ALSC_MUX_AUX_TEMP) pd = alsc_pkg::PD_TEMP;
        else if (code == `ALSC_MUX_AUX_VDD) pd = alsc_pkg::PD_VDD;
      end
      default: pd = alsc_pkg::PD_NONE;
    endcase
    return pd;
  endfunction : alscDecodeMux

  // Exponent in the high nibble, mantissa with hidden one in the low nibble
  function automatic logic [15:0] alscExpand(input logic [7:0] code);
    logic [19:0] wide;
    wide = 20'({1'b1, code[3:0]}) << code[7:4];
    return wide[19:4];
  endfunction : alscExpand

  // Bus decode
  logic [5:0] regIdx;
  logic setup;
  logic access;
  logic wrEn;
  logic selIr, selAux, selRec, selGain, selMisc, selHyst, selCtrl, selStat;
  logic selIrqS, selIrqM, selLow, selHigh, selHist, selRv, selRi, selRa, selHx;
  logic hit;
  logic [31:0] rdMux;

  assign regIdx = paddr[7:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wrEn = access && pwrite;
  assign selIr = (regIdx == `ALSC_IDX_IR_SEL);
  assign selAux = (regIdx == `ALSC_IDX_AUX_SEL);
  assign selRec = (regIdx == `ALSC_IDX_VIS_REC);
  assign selGain = (regIdx == `ALSC_IDX_VIS_GAIN);
  assign selMisc = (regIdx == `ALSC_IDX_VIS_MISC);
  assign selHyst = (regIdx == `ALSC_IDX_HYST);
  assign selCtrl = (regIdx == `ALSC_IDX_CTRL);
  assign selStat = (regIdx == `ALSC_IDX_STATUS);
  assign selIrqS = (regIdx == `ALSC_IDX_IRQ_STAT);
  assign selIrqM = (regIdx == `ALSC_IDX_IRQ_MASK);
  assign selLow = (regIdx == `ALSC_IDX_LOW_TH);
  assign selHigh = (regIdx == `ALSC_IDX_HIGH_TH);
  assign selHist = (regIdx == `ALSC_IDX_HISTORY);
  assign selRv = (regIdx == `ALSC_IDX_RES_VIS);
  assign selRi = (regIdx == `ALSC_IDX_RES_IR);
  assign selRa = (regIdx == `ALSC_IDX_RES_AUX);
  assign selHx = (regIdx == `ALSC_IDX_HYST_EXP);
  assign hit = (paddr[1:0] == 2'h0) && (selIr || selAux || selRec || selGain
    || selMisc || selHyst || selCtrl || selStat || selIrqS || selIrqM
    || selLow || selHigh || selHist || selRv || selRi || selRa || selHx);

  // Zero wait states; unmapped or misaligned accesses fail and change nothing
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  logic [15:0] hystExp;
  logic busy;
  assign hystExp = alscExpand(lightThresholdHysteresis);
  assign busy = (state != alsc_pkg::ST_IDLE);

  assign rdMux = ({32{selIr}} & {24'h000000, irInputSelect})
    | ({32{selAux}} & {24'h000000, auxiliaryInputSelect})
    | ({32{selRec}} & {24'h000000, visibleRecoveryConfig})
    | ({32{selGain}} & {24'h000000, visibleIntegrationScale})
    | ({32{selMisc}} & {24'h000000, visibleMiscConfig})
    | ({32{selHyst}} & {24'h000000, lightThresholdHysteresis})
    | ({32{selStat}} & {26'h0000000, legacySync2, belowLower, aboveUpper, chan, busy})
    | ({32{selIrqS}} & {29'h00000000, irqStat})
    | ({32{selIrqM}} & {29'h00000000, irqMask})
    | ({32{selLow}} & {16'h0000, lightLowerThreshold})
    | ({32{selHigh}} & {16'h0000, lightUpperThreshold})
    | ({32{selHist}} & {24'h000000, lightConsecutiveCount})
    | ({32{selRv}} & {16'h0000, resVis})
    | ({32{selRi}} & {16'h0000, resIr})
    | ({32{selRa}} & {16'h0000, resAux})
    | ({32{selHx}} & {16'h0000, hystExp});

  // Read data is captured in the setup phase so it stands from a flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) prdata <= 32'h00000000;
    else if (setup) prdata <= (!pwrite && hit) ? rdMux : 32'h00000000;
  end

  // Settings keep their value until written or reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irInputSelect <= `ALSC_RST_IR_SEL;
      auxiliaryInputSelect <= `ALSC_RST_AUX_SEL;
      visibleRecoveryConfig <= `ALSC_RST_VIS_REC;
      visibleIntegrationScale <= `ALSC_RST_VIS_GAIN;
      visibleMiscConfig <= `ALSC_RST_VIS_MISC;
      lightThresholdHysteresis <= `ALSC_RST_HYST;
      lightConsecutiveCount <= `ALSC_RST_HISTORY;
    end else if (wrEn && hit) begin
      if (selIr) irInputSelect <= pwdata[7:0];
      if (selAux) auxiliaryInputSelect <= pwdata[7:0];
      if (selRec) visibleRecoveryConfig <= pwdata[7:0] & `ALSC_WMASK_VIS_REC;
      if (selGain) visibleIntegrationScale <= pwdata[7:0] & `ALSC_WMASK_VIS_GAIN;
      if (selMisc) visibleMiscConfig <= pwdata[7:0] & `ALSC_WMASK_VIS_MISC;
      if (selHyst) lightThresholdHysteresis <= pwdata[7:0];
      if (selHist) lightConsecutiveCount <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lightLowerThreshold <= `ALSC_RST_LOW_TH;
      lightUpperThreshold <= `ALSC_RST_HIGH_TH;
      irqMask <= 3'h0;
    end else if (wrEn && hit) begin
      if (selLow) lightLowerThreshold <= pwdata[15:0];
      if (selHigh) lightUpperThreshold <= pwdata[15:0];
      if (selIrqM) irqMask <= pwdata[2:0];
    end
  end

  // Strap synchroniser; only the second stage is used
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      legacySync1 <= 1'b0;
      legacySync2 <= 1'b0;
    end else begin
      legacySync1 <= legacyRev;
      legacySync2 <= legacySync1;
    end
  end

  // Measurement start; requests while busy are dropped
  logic wrCtrl;
  logic startVis, startIr, startAux, startAny;
  assign wrCtrl = wrEn && hit && selCtrl && !busy;
  assign startVis = wrCtrl && pwdata[`ALSC_CTRL_VIS];
  assign startIr = wrCtrl && !pwdata[`ALSC_CTRL_VIS] && pwdata[`ALSC_CTRL_IR];
  assign startAux = wrCtrl && !pwdata[`ALSC_CTRL_VIS] && !pwdata[`ALSC_CTRL_IR]
    && pwdata[`ALSC_CTRL_AUX];
  assign startAny = startVis || startIr || startAux;

  // Channel settings; older silicon runs IR on the visible settings
  logic useVisCfg;
  logic [2:0] actGain;
  logic [2:0] actRec;
  logic actRange;
  logic [9:0] recClocks;
  logic [9:0] loadClocks;
  logic timerLoad;
  logic timerTick;
  logic timerDone;
  alsc_pkg::alsc_chan_e selChan;

  assign selChan = startVis ? alsc_pkg::CH_VIS
    : (startIr ? alsc_pkg::CH_IR : (startAux ? alsc_pkg::CH_AUX : chan));
  assign useVisCfg = (selChan == alsc_pkg::CH_VIS)
    || ((selChan == alsc_pkg::CH_IR) && legacySync2);
  assign actGain = useVisCfg ? visibleIntegrationScale[`ALSC_GAIN_MSB:0]
    : ((selChan == alsc_pkg::CH_IR) ? `ALSC_IR_DEF_GAIN : 3'h0);
  assign actRec = useVisCfg ? visibleRecoveryConfig[`ALSC_REC_MSB:`ALSC_REC_LSB]
    : ((selChan == alsc_pkg::CH_IR) ? `ALSC_IR_DEF_REC : 3'h0);
  assign actRange = useVisCfg && visibleMiscConfig[`ALSC_RANGE_BIT];
  // Codes 0..7 give 1, 7, 15, ... 511 ADC clocks
  assign recClocks = (actRec == 3'h0) ? 10'h001 : 10'((10'h004 << actRec) - 10'h001);
  assign timerLoad = startAny || ((state == alsc_pkg::ST_RECOV) && timerDone);
  assign loadClocks = startAny ? recClocks : `ALSC_INTEG_ADC_CLKS;

  // Same divided ADC clock paces recovery and integration
  alsc_adc_timer uTimer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(timerLoad),
    .gain(actGain),
    .adcClocks(loadClocks),
    .adcTick(timerTick),
    .done(timerDone)
  );

  always_comb begin
    next_state = state;
    case (state)
      alsc_pkg::ST_IDLE: if (startAny) next_state = alsc_pkg::ST_RECOV;
      alsc_pkg::ST_RECOV: if (timerDone) next_state = alsc_pkg::ST_INTEG;
      alsc_pkg::ST_INTEG: if (timerDone) next_state = alsc_pkg::ST_SAMPLE;
      alsc_pkg::ST_SAMPLE: begin
        if (sample.valid) begin
          next_state = (chan == alsc_pkg::CH_VIS) ? alsc_pkg::ST_EVAL : alsc_pkg::ST_IDLE;
        end
      end
      alsc_pkg::ST_EVAL: next_state = alsc_pkg::ST_IDLE;
      default: next_state = alsc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= alsc_pkg::ST_IDLE;
      chan <= alsc_pkg::CH_VIS;
    end else begin
      state <= next_state;
      if (startAny) chan <= selChan;
    end
  end

  assign sampleReq = (state == alsc_pkg::ST_SAMPLE);

  always_comb begin
    next_feCtrl.pdSel = busy || startAny
      ? alscDecodeMux(selChan, (selChan == alsc_pkg::CH_AUX) ? auxiliaryInputSelect
      : irInputSelect) : alsc_pkg::PD_NONE;
    next_feCtrl.refGround = (selChan == alsc_pkg::CH_AUX) && (busy || startAny);
    next_feCtrl.rangeHigh = actRange;
    next_feCtrl.integrate = (next_state == alsc_pkg::ST_INTEG);
    next_feCtrl.gain = actGain;
    next_feCtrl.adcTick = timerTick;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) feCtrl <= '0;
    else feCtrl <= next_feCtrl;
  end

  // Results per channel
  logic sampleTaken;
  logic [15:0] sampleHeld;
  assign sampleTaken = (state == alsc_pkg::ST_SAMPLE) && sample.valid;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      resVis <= 16'h0000;
      resIr <= 16'h0000;
      resAux <= 16'h0000;
      sampleHeld <= 16'h0000;
    end else if (sampleTaken) begin
      sampleHeld <= sample.data;
      if (chan == alsc_pkg::CH_VIS) resVis <= sample.data;
      if (chan == alsc_pkg::CH_IR) resIr <= sample.data;
      if (chan == alsc_pkg::CH_AUX) resAux <= sample.data;
    end
  end

  // Threshold bands widened by the hysteresis on both sides
  logic [16:0] upperBand;
  logic [16:0] lowerProbe;
  logic [2:0] cond;
  logic [2:0] match;
  logic evalEn;
  assign upperBand = {1'b0, lightUpperThreshold} + {1'b0, hystExp};
  assign lowerProbe = {1'b0, sampleHeld} + {1'b0, hystExp};
  assign cond[0] = ({1'b0, sampleHeld} > upperBand);
  assign cond[1] = (lowerProbe < {1'b0, lightLowerThreshold});
  assign cond[2] = !cond[0] && !cond[1];
  assign evalEn = (state == alsc_pkg::ST_EVAL);

  // History of above, below and inside; the mask picks how many in a row
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gHist
      logic [7:0] hist;
      logic [7:0] histNext;
      assign histNext = {hist[6:0], cond[g]};
      assign match[g] = ((histNext & lightConsecutiveCount)
        == lightConsecutiveCount);
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) hist <= 8'h00;
        else if (evalEn) hist <= histNext;
      end
    end
  endgenerate

  logic evHigh;
  logic evLow;
  assign evHigh = evalEn && cond[0] && match[0] && !aboveUpper;
  assign evLow = evalEn && cond[1] && match[1] && !belowLower;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aboveUpper <= 1'b0;
      belowLower <= 1'b0;
    end else if (evalEn) begin
      if (cond[0] && match[0]) begin
        aboveUpper <= 1'b1;
        belowLower <= 1'b0;
      end else if (cond[1] && match[1]) begin
        aboveUpper <= 1'b0;
        belowLower <= 1'b1;
      end else if (cond[2] && match[2]) begin
        aboveUpper <= 1'b0;
        belowLower <= 1'b0;
      end
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  logic [2:0] events;
  logic [2:0] clrBits;
  assign events[`ALSC_IRQ_DONE] = sampleTaken;
  assign events[`ALSC_IRQ_HIGH] = evHigh;
  assign events[`ALSC_IRQ_LOW] = evLow;
  assign clrBits = (wrEn && hit && selIrqS) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) irqStat <= 3'h0;
    else irqStat <= (irqStat & ~clrBits) | events;
  end

  assign irq = |(irqStat & irqMask);

endmodule : alsc_light_setup

// file: verification/alsc_fe_model.sv
`timescale 1ns/1ps

module alsc_fe_model (
  // Clock and reset
  input logic clk_sys,
  input logic arst_n,
  // Conversion handshake
  input logic sampleReq,
  output alsc_pkg::alsc_sample_s sample,
  // Set by the bench
  input logic [15:0] level,
  input logic [3:0] delay
);
  logic [3:0] waitCnt;

  // Data toggles outside valid, so a stale word cannot pass
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt <= 4'h0;
      sample <= '0;
    end else begin
      sample.valid <= 1'b0;
      sample.data <= ~sample.data;
      if (sampleReq && !sample.valid) begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == delay) begin
          waitCnt <= 4'h0;
          sample.valid <= 1'b1;
          sample.data <= level;
        end
      end
    end
  end
endmodule : alsc_fe_model

// file: verification/alsc_light_setup_properties.sv
`timescale 1ns/1ps
`include "alsc_consts.svh"

module alsc_light_setup_properties (
  // Clock and reset
  input logic clk_sys,
  input logic arst_n,
  // APB
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Strap, front end, interrupt
  input logic legacyRev,
  input alsc_pkg::alsc_fe_s feCtrl,
  input logic sampleReq,
  input alsc_pkg::alsc_sample_s sample,
  input logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [7:0] irSel, auxSel, visRec, visGain, visMisc, hyst, cfgVal;
  logic [2:0] irqMask;
  logic [5:0] idx;
  logic wrAcc, rdAcc, isCfg, isMapped, isIr, isAux;
  logic [31:0] hystExp;
  assign idx = paddr[7:2];
  assign wrAcc = psel && penable && pwrite && pready && (paddr[1:0] == 2'h0);
  assign rdAcc = psel && penable && !pwrite && (paddr[1:0] == 2'h0);
  assign isMapped = isCfg || (idx >= `ALSC_IDX_CTRL && idx <= `ALSC_IDX_HYST_EXP);
  assign hystExp = ({27'h0, 1'b1, hyst[3:0]} << hyst[7:4]) >> 4;
  assign isIr = feCtrl.pdSel inside {alsc_pkg::PD_IR_SMALL, alsc_pkg::PD_IR_LARGE};
  assign isAux = feCtrl.pdSel inside {alsc_pkg::PD_TEMP, alsc_pkg::PD_VDD};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irSel <= `ALSC_RST_IR_SEL;
      auxSel <= `ALSC_RST_AUX_SEL;
      visRec <= `ALSC_RST_VIS_REC;
      visGain <= `ALSC_RST_VIS_GAIN;
      visMisc <= `ALSC_RST_VIS_MISC;
      hyst <= `ALSC_RST_HYST;
      irqMask <= 3'h0;
    end else if (wrAcc) begin
      if (idx == `ALSC_IDX_IR_SEL) irSel <= pwdata[7:0];
      if (idx == `ALSC_IDX_AUX_SEL) auxSel <= pwdata[7:0];
      if (idx == `ALSC_IDX_VIS_REC) visRec <= pwdata[7:0] & `ALSC_WMASK_VIS_REC;
      if (idx == `ALSC_IDX_VIS_GAIN) visGain <= pwdata[7:0] & `ALSC_WMASK_VIS_GAIN;
      if (idx == `ALSC_IDX_VIS_MISC) visMisc <= pwdata[7:0] & `ALSC_WMASK_VIS_MISC;
      if (idx == `ALSC_IDX_HYST) hyst <= pwdata[7:0];
      if (idx == `ALSC_IDX_IRQ_MASK) irqMask <= pwdata[2:0];
    end
  end

  always_comb begin
    isCfg = 1'b1;
    case (idx)
      `ALSC_IDX_IR_SEL: cfgVal = irSel;
      `ALSC_IDX_AUX_SEL: cfgVal = auxSel;
      `ALSC_IDX_VIS_REC: cfgVal = visRec;
      `ALSC_IDX_VIS_GAIN: cfgVal = visGain;
      `ALSC_IDX_VIS_MISC: cfgVal = visMisc;
      `ALSC_IDX_HYST: cfgVal = hyst;
      default: begin
        cfgVal = 8'h00;
        isCfg = 1'b0;
      end
    endcase
  end

  AST_IR_SEL: assert property (isIr |-> feCtrl.pdSel == ($past(irSel) ==
    `ALSC_MUX_IR_LARGE ? alsc_pkg::PD_IR_LARGE : alsc_pkg::PD_IR_SMALL)) else $error("IR input");
  AST_AUX_SEL: assert property (isAux |-> feCtrl.pdSel == ($past(auxSel) ==
    `ALSC_MUX_AUX_VDD ? alsc_pkg::PD_VDD : alsc_pkg::PD_TEMP)) else $error("aux input");
  AST_AUX_GROUND: assert property (isAux |-> feCtrl.refGround)
    else $error("aux reference");
  AST_CFG_READBACK: assert property (rdAcc && isCfg |-> prdata == {24'h0, cfgVal})
    else $error("readback");
  AST_HYST_EXPAND: assert property (rdAcc && idx == `ALSC_IDX_HYST_EXP |-> prdata == hystExp)
    else $error("hysteresis");
  AST_VIS_GAIN: assert property (feCtrl.pdSel == alsc_pkg::PD_VIS |->
    feCtrl.gain == $past(visGain[2:0])) else $error("visible gain");
  AST_VISIBLE_SIGNAL_RANGE: assert property (feCtrl.pdSel == alsc_pkg::PD_VIS |->
    feCtrl.rangeHigh == $past(visMisc[5])) else $error("visible range");
  AST_IR_LEGACY: assert property (isIr |-> (legacyRev ?
    (feCtrl.gain == $past(visGain[2:0]) && feCtrl.rangeHigh == $past(visMisc[5])) :
    (feCtrl.gain == `ALSC_IR_DEF_GAIN && !feCtrl.rangeHigh))) else $error("IR settings");
  AST_SAMPLE_HOLD: assert property (sampleReq && !sample.valid |=> sampleReq)
    else $error("sample request");
  AST_BAD_ADDR: assert property (psel && penable && (!isMapped || paddr[1:0] != 2'h0) |->
    pslverr && prdata == 32'h0) else $error("unmapped");
  AST_IRQ_MASKED: assert property (irqMask == 3'h0 |-> !irq) else $error("masked irq");
  AST_IRQ_DONE: assert property (sampleReq && sample.valid && irqMask[0] |-> ##[1:2] irq)
    else $error("done irq");

  COV_VIS: cover property (sampleReq && sample.valid && feCtrl.pdSel == alsc_pkg::PD_VIS);
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pslverr);
endmodule : alsc_light_setup_properties

bind alsc_light_setup alsc_light_setup_properties alsc_light_setup_properties_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .legacyRev(legacyRev), .feCtrl(feCtrl), .sampleReq(sampleReq), .sample(sample), .irq(irq));

// file: verification/tb.sv
`timescale 1ns/1ps
`include "alsc_consts.svh"

module tb;
  logic clk_sys = 1'b0;
  logic arst_n, psel, penable, pwrite, pready, pslverr, legacyRev, sampleReq, irq, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] level;
  logic [3:0] feDelay;
  alsc_pkg::alsc_fe_s feCtrl;
  alsc_pkg::alsc_sample_s sample;
  int badCount = 0, cmpCount = 0, cycles = 0;
  logic [5:0] cfgIdx [6] = '{`ALSC_IDX_IR_SEL, `ALSC_IDX_AUX_SEL, `ALSC_IDX_VIS_REC,
    `ALSC_IDX_VIS_GAIN, `ALSC_IDX_VIS_MISC, `ALSC_IDX_HYST};
  logic [7:0] cfgRst [6] = '{`ALSC_RST_IR_SEL, `ALSC_RST_AUX_SEL, `ALSC_RST_VIS_REC,
    `ALSC_RST_VIS_GAIN, `ALSC_RST_VIS_MISC, `ALSC_RST_HYST};
  logic [7:0] cfgMask [6] = '{8'hFF, 8'hFF, `ALSC_WMASK_VIS_REC, `ALSC_WMASK_VIS_GAIN,
    `ALSC_WMASK_VIS_MISC, 8'hFF};
  logic [2:0] tGain [4] = '{3'h0, 3'h3, 3'h7, 3'h1};
  logic [2:0] tRec [4] = '{3'h7, 3'h4, 3'h0, 3'h0};
  logic [15:0] thVal [6] = '{16'h0400, 16'h0401, 16'h0401, 16'h004C, 16'h004B, 16'h004B};
  int thBit [6] = '{3, 3, 3, 4, 4, 4};
  logic thExp [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  always #25 clk_sys = ~clk_sys;

  alsc_light_setup alsc_light_setup_inst (.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .legacyRev(legacyRev), .feCtrl(feCtrl),
    .sampleReq(sampleReq), .sample(sample), .irq(irq));
  alsc_fe_model alsc_fe_model_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .sampleReq(sampleReq), .sample(sample), .level(level), .delay(feDelay));

  task conclude;
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task rdc(input string name, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(name, rdv, exp);
  endtask : rdc

  task irqChk(input logic exp);
    @(negedge clk_sys);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irqChk

  function automatic int recClks(input logic [2:0] c);
    return (c == 3'h0) ? 1 : (1 << (c + 2)) - 1;
  endfunction : recClks

  // Time one conversion to the sample request, then wait for idle
  task measure(input logic [2:0] ctrl, input int exp);
    int n;
    wr(`ALSC_IDX_CTRL, {29'h0, ctrl});
    for (n = 0; sampleReq !== 1'b1 && n < 5000; n++) @(negedge clk_sys);
    check("sampleTime", {31'h0, n >= exp && n <= exp + 2}, 32'h1);
    rdv = 32'h1;
    for (int k = 0; k < 20 && rdv[0] === 1'b1; k++) apb(1'b0, `ALSC_IDX_STATUS, 32'h0);
  endtask : measure

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      badCount++;
      conclude();
    end
  end

  initial begin
    {arst_n, psel, penable, pwrite, legacyRev, paddr, pwdata, level, feDelay} = 65'h0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdc("rstVal", cfgIdx[i], {24'h0, cfgRst[i]});
      wr(cfgIdx[i], 32'hFFFFFFFF);
      rdc("wrBits", cfgIdx[i], {24'h0, cfgMask[i]});
      wr(cfgIdx[i], {24'h0, cfgRst[i]});
    end
    rdc("hystExp", `ALSC_IDX_HYST_EXP, 32'd24);
    apb(1'b0, 6'h13, 32'h0);
    check("badErr", {31'h0, errv}, 32'h1);
    check("badData", rdv, 32'h0);
    // Recovery set to the complement of gain except the last row
    for (int i = 0; i < 4; i++) begin
      wr(`ALSC_IDX_VIS_GAIN, {29'h0, tGain[i]});
      wr(`ALSC_IDX_VIS_REC, {25'h0, tRec[i], 4'h0});
      level <= 16'h0100 + 16'(i);
      feDelay <= 4'(i * 4);
      measure(3'h1, (recClks(tRec[i]) + 16) << tGain[i]);
      rdc("visRes", `ALSC_IDX_RES_VIS, 32'h0100 + i);
    end
    wr(`ALSC_IDX_VIS_MISC, 32'h20);
    for (int i = 0; i < 2; i++) begin
      wr(`ALSC_IDX_IR_SEL, {24'h0, i ? `ALSC_MUX_IR_LARGE : `ALSC_MUX_IR_SMALL});
      legacyRev <= i[0];
      level <= 16'h0200 + 16'(i);
      measure(3'h2, i ? 34 : 527);
      rdc("irRes", `ALSC_IDX_RES_IR, 32'h0200 + i);
      wr(`ALSC_IDX_AUX_SEL, {24'h0, i ? `ALSC_MUX_AUX_VDD : `ALSC_MUX_AUX_TEMP});
      measure(3'h4, 17);
      rdc("auxRes", `ALSC_IDX_RES_AUX, 32'h0200 + i);
    end
    wr(`ALSC_IDX_VIS_GAIN, 32'h0);
    wr(`ALSC_IDX_VIS_REC, 32'h0);
    wr(`ALSC_IDX_VIS_MISC, 32'h0);
    wr(`ALSC_IDX_HIGH_TH, 32'd1000);
    wr(`ALSC_IDX_LOW_TH, 32'd100);
    irqChk(1'b0);
    wr(`ALSC_IDX_IRQ_MASK, 32'h2);
    // Band edges sit one hysteresis step of 24 outside each threshold
    for (int i = 0; i < 6; i++) begin
      level <= thVal[i];
      measure(3'h1, 17);
      apb(1'b0, `ALSC_IDX_STATUS, 32'h0);
      check("thStatus", {31'h0, rdv[thBit[i]]}, {31'h0, thExp[i]});
    end
    irqChk(1'b1);
    wr(`ALSC_IDX_IRQ_STAT, 32'h2);
    irqChk(1'b0);
    wr(`ALSC_IDX_IRQ_MASK, 32'h1);
    irqChk(1'b1);
    wr(`ALSC_IDX_IRQ_STAT, 32'h1);
    irqChk(1'b0);
    measure(3'h4, 17);
    irqChk(1'b1);
    conclude();
  end
endmodule : tb
